// file: rtl/negnop_cfg.svh
// Constants for the negate and no-operation execution block.
// Functional notes
// - Negate the addressed data byte in two's complement and write it back there.
// - Negate is recognised by seven fixed upper bits, access bit, eight-bit address.
// - Negate updates negative, overflow, carry, digit-carry, zero; one word, one cycle.
// - Access bit zero selects access bank; one selects bank from bank pointer.
// - Extended set, access bit zero, address at most 95 means indexed literal offset.
// - All-zero word and top nibble all ones are no-operations, one cycle, no flags.
`ifndef NEGNOP_CFG_SVH
`define NEGNOP_CFG_SVH
`define NEG_OPC_VAL       7'h36
`define NEG_OPC_MSB       15
`define NEG_OPC_LSB       9
`define ACCESS_BIT        8
`define NOP_NIB_VAL       4'hF
`define INDEXED_MAX       8'h5F
`define ACCESS_HI_BANK    4'hF
`define ACCESS_SPLIT      8'h60
`define FLAG_NEG          4
`define FLAG_OV           3
`define FLAG_Z            2
`define FLAG_DC           1
`define FLAG_C            0
`define STATUS_RESET      5'h00
`endif

// file: rtl/negnop_pkg.sv
// Types shared by the negate and no-operation execution block.
package negnop_pkg;
  typedef enum logic [1:0] {
    PH_Q1,
    PH_Q2,
    PH_Q3,
    PH_Q4
  } phase_e;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_NEG,
    OP_NOP
  } op_e;
  // Data-memory access request.
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } mem_req_s;
endpackage

// file: rtl/negnop_decode.sv
// Opcode decoder and effective address generator.
`include "negnop_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module negnop_decode (
  input  wire logic [15:0]     i_word,
  input  wire logic [3:0]      i_bank_pointer,
  input  wire logic            i_ext_en,
  input  wire logic [7:0]      i_fsr2,
  output logic                 o_is_neg,
  output logic                 o_is_nop,
  output logic [11:0]          o_addr
);
  wire       access_sel = i_word[`ACCESS_BIT];
  wire [7:0] f_field    = i_word[7:0];
  wire       indexed    = i_ext_en & ~access_sel & (f_field <= `INDEXED_MAX);
  wire [7:0] idx_sum    = 8'(i_fsr2 + f_field); // The carry out of the index sum is dropped.
  wire [3:0] acc_bank   = (f_field < `ACCESS_SPLIT) ? 4'h0 : `ACCESS_HI_BANK;

  // Opcode match for negate and the two no-operation forms.
  assign o_is_neg = (i_word[`NEG_OPC_MSB:`NEG_OPC_LSB] == `NEG_OPC_VAL);
  assign o_is_nop = (i_word == 16'h0000) || (i_word[15:12] == `NOP_NIB_VAL);
  // Indexed offset wins over access bank; access bit one uses the bank pointer.
  assign o_addr = indexed ? {4'h0, idx_sum} :
                  access_sel ? {i_bank_pointer, f_field} : {acc_bank, f_field};
endmodule
`default_nettype wire

// file: rtl/negnop_exec.sv
// Four-phase execution unit for negate and no-operation instructions.
`include "negnop_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module negnop_exec (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [15:0]           i_instr,
  input  wire logic [3:0]            i_bank_pointer,
  input  wire logic                  i_ext_en,
  input  wire logic [7:0]            i_fsr2,
  input  wire logic [7:0]            i_rdata,
  output negnop_pkg::mem_req_s       o_mem,
  output logic [4:0]                 o_status,
  output logic [1:0]                 o_phase,
  output logic                       o_done
);
  negnop_pkg::phase_e phase;
  negnop_pkg::phase_e next_phase;
  negnop_pkg::op_e    op;
  logic [11:0]        addr;
  logic [7:0]         opnd;
  logic [4:0]         flags;
  wire                dec_neg;
  wire                dec_nop;
  wire [11:0]         dec_addr;

  negnop_decode u_decode (
    .i_word         (i_instr),
    .i_bank_pointer (i_bank_pointer),
    .i_ext_en       (i_ext_en),
    .i_fsr2         (i_fsr2),
    .o_is_neg       (dec_neg),
    .o_is_nop       (dec_nop),
    .o_addr         (dec_addr)
  );

  // Negation result and its flags from the read operand.
  wire [8:0] sum9   = {1'b0, ~opnd} + 9'h001;
  wire [4:0] sum5   = {1'b0, ~opnd[3:0]} + 5'h01;
  wire [7:0] neg    = sum9[7:0];
  wire [4:0] nflags;
  assign nflags[`FLAG_NEG] = neg[7];
  assign nflags[`FLAG_OV]  = (opnd == 8'h80); // Only the most negative byte overflows.
  assign nflags[`FLAG_Z]   = (neg == 8'h00);
  assign nflags[`FLAG_DC]  = sum5[4];
  assign nflags[`FLAG_C]   = sum9[8];

  // Phase sequencing: one instruction cycle is four clock phases.
  always_comb begin
    case (phase)
      negnop_pkg::PH_Q1: next_phase = negnop_pkg::PH_Q2;
      negnop_pkg::PH_Q2: next_phase = negnop_pkg::PH_Q3;
      negnop_pkg::PH_Q3: next_phase = negnop_pkg::PH_Q4;
      default:           next_phase = negnop_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= negnop_pkg::PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // Q1 decode, Q2 read, Q3 compute, Q4 write back to the same location.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op     <= negnop_pkg::OP_NONE;
      addr   <= 12'h000;
      opnd   <= 8'h00;
      flags  <= `STATUS_RESET;
      o_mem  <= '0;
      o_done <= 1'b0;
    end else begin
      o_mem.rd <= 1'b0;
      o_mem.wr <= 1'b0;
      o_done   <= 1'b0;
      case (phase)
        negnop_pkg::PH_Q1: begin
          op   <= dec_neg ? negnop_pkg::OP_NEG :
                  dec_nop ? negnop_pkg::OP_NOP : negnop_pkg::OP_NONE;
          addr <= dec_addr;
          if (dec_neg) begin
            o_mem.addr <= dec_addr;
            o_mem.rd   <= 1'b1;
          end
        end
        negnop_pkg::PH_Q2: begin
          opnd <= i_rdata;
        end
        negnop_pkg::PH_Q3: begin
          if (op == negnop_pkg::OP_NEG) begin
            flags  <= nflags;
            o_mem.addr  <= addr;
            o_mem.wdata <= neg;
            o_mem.wr    <= 1'b1;
          end
        end
        default: begin
          o_done <= (op != negnop_pkg::OP_NONE);
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_status <= `STATUS_RESET;
      o_phase  <= 2'b00;
    end else begin
      o_status <= flags;
      o_phase  <= next_phase;
    end
  end

  // Write-back goes to the address that was read.
  write_same_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_mem.rd |=> ##1 (o_mem.wr && o_mem.addr == $past(o_mem.addr, 2)))
    else $error("negate write address differs from read address");
  neg_value_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_mem.wr |-> o_mem.wdata == 8'(~opnd + 8'h01))
    else $error("negate result wrong");
  zero_flag_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_mem.wr |=> flags[`FLAG_Z] == ($past(o_mem.wdata) == 8'h00))
    else $error("zero flag wrong");
  one_cycle_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_mem.rd |-> ##3 o_done)
    else $error("negate not done within one instruction cycle");
  nop_flags_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (phase == negnop_pkg::PH_Q1 && dec_nop) |=> ##3 flags == $past(flags, 4))
    else $error("no-operation changed flags");
  bank_sel_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (phase == negnop_pkg::PH_Q1 && dec_neg && i_instr[`ACCESS_BIT])
      |=> o_mem.addr[11:8] == $past(i_bank_pointer))
    else $error("bank pointer not used");
  indexed_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (phase == negnop_pkg::PH_Q1 && dec_neg && i_ext_en && !i_instr[`ACCESS_BIT]
      && i_instr[7:0] <= `INDEXED_MAX)
      |=> o_mem.addr[7:0] == 8'($past(i_fsr2) + $past(i_instr[7:0]))
          && o_mem.addr[11:8] == 4'h0)
    else $error("indexed offset address wrong");

  // Steps of one instruction cycle, from the decode phase to the write phase.
  sequence cycle_walk_s;
    phase == negnop_pkg::PH_Q1 ##1 phase == negnop_pkg::PH_Q2 ##1
      phase == negnop_pkg::PH_Q3 ##1 phase == negnop_pkg::PH_Q4;
  endsequence

  // Read pulse of a negate, then one quiet phase while the result is formed.
  sequence neg_read_s;
    o_mem.rd ##1 (!o_mem.rd && !o_mem.wr);
  endsequence

  // Write pulse of a negate, then the completion pulse.
  sequence neg_write_s;
    o_mem.wr ##1 o_done;
  endsequence

  // The phase counter walks through all four phases in order.
  phase_seq_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    phase == negnop_pkg::PH_Q1 |-> cycle_walk_s)
    else $error("phase order wrong");

  // A negate reads, waits, writes and completes within one instruction cycle.
  neg_steps_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_mem.rd |-> neg_read_s ##1 neg_write_s)
    else $error("negate steps out of order");

  // The read strobe only appears in the read phase.
  read_phase_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_mem.rd |-> phase == negnop_pkg::PH_Q2)
    else $error("read outside the read phase");

  // The write strobe only appears in the write phase.
  write_phase_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_mem.wr |-> phase == negnop_pkg::PH_Q4)
    else $error("write outside the write phase");

  // Overflow is set only when the operand was the most negative byte.
  ov_flag_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_mem.wr |=> flags[`FLAG_OV] == ($past(opnd) == 8'h80))
    else $error("overflow flag wrong");

  // Carry out of the negation is set only for a zero operand.
  carry_flag_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_mem.wr |=> flags[`FLAG_C] == ($past(opnd) == 8'h00))
    else $error("carry flag wrong");

  // Digit carry is set only when the operand's low nibble was zero.
  dc_flag_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_mem.wr |=> flags[`FLAG_DC] == ($past(opnd[3:0]) == 4'h0))
    else $error("digit carry flag wrong");

  // Negative follows the sign of the written result.
  neg_flag_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_mem.wr |=> flags[`FLAG_NEG] == $past(o_mem.wdata[7]))
    else $error("negative flag wrong");

  // A no-operation touches no memory.
  nop_quiet_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (phase == negnop_pkg::PH_Q1 && dec_nop) |=> !o_mem.rd ##2 !o_mem.wr)
    else $error("no-operation accessed memory");

  // An unrecognised word neither accesses memory nor completes.
  refuse_word_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (phase == negnop_pkg::PH_Q1 && !dec_neg && !dec_nop)
      |=> !o_mem.rd ##2 !o_mem.wr ##1 !o_done)
    else $error("unrecognised word acted on");

  // Access bit clear without indexing splits the access bank at the boundary.
  access_bank_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (phase == negnop_pkg::PH_Q1 && dec_neg && !i_ext_en && !i_instr[`ACCESS_BIT])
      |=> o_mem.addr[11:8] == (($past(i_instr[7:0]) < `ACCESS_SPLIT) ? 4'h0
                                                               : `ACCESS_HI_BANK))
    else $error("access bank address wrong");

  // The status output trails the internal flags by one clock.
  status_copy_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_status == $past(flags))
    else $error("status output out of step");

  // The phase output always shows the current phase.
  phase_out_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_phase == 2'(phase))
    else $error("phase output wrong");
endmodule
`default_nettype wire

// file: tb/negate_and_nop_execution_tb.sv
// Self-checking testbench for the negate and no-operation execution block.
`timescale 1ns/1ps
`default_nettype none
module negate_and_nop_execution_tb;
  logic                 i_core_clk = 1'b0;
  logic                 i_rst_n = 1'b0;
  logic [15:0]          i_instr = 16'h0000;
  logic [3:0]           i_bank_pointer = 4'h0;
  logic                 i_ext_en = 1'b0;
  logic [7:0]           i_fsr2 = 8'h00;
  logic [7:0]           i_rdata = 8'h00;
  negnop_pkg::mem_req_s o_mem;
  logic [4:0]           o_status;
  logic [1:0]           o_phase;
  logic                 o_done;
  logic [4:0]           st = 5'h00;
  logic                 pend = 1'b0;
  int                   n_mismatch = 0;
  int                   checked = 0;

  negnop_exec dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_instr(i_instr),
    .i_bank_pointer(i_bank_pointer), .i_ext_en(i_ext_en), .i_fsr2(i_fsr2),
    .i_rdata(i_rdata), .o_mem(o_mem), .o_status(o_status), .o_phase(o_phase),
    .o_done(o_done));

  // A 20 ns half period gives the 25 MHz core clock.
  always #20 i_core_clk = ~i_core_clk;

  // Counts every comparison and reports a difference at once.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Flags {negative, overflow, zero, digit carry, carry} of a negated byte.
  function automatic logic [4:0] neg_flags(input logic [7:0] f);
    logic [7:0] r;
    r = 8'h00 - f;
    return {r[7], f == 8'h80, r == 8'h00, f[3:0] == 4'h0, f == 8'h00};
  endfunction

  // Issues one word at this edge; the previous word's completion is judged first.
  task automatic op(input logic [15:0] w, input logic [7:0] d, input logic acc,
                    input logic dn, input logic [11:0] a);
    i_instr <= w;
    i_rdata <= d;
    @(negedge i_core_clk);
    cmp({o_done, o_status}, {pend, st});
    @(posedge i_core_clk);
    @(negedge i_core_clk);
    cmp({o_phase, o_mem.rd, acc ? o_mem.addr : 12'h000}, {2'h1, acc, a});
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk);
    cmp({o_phase, o_mem.wr}, {2'h3, acc});
    if (acc) cmp({o_mem.addr, o_mem.wdata}, {a, 8'h00 - d});
    @(posedge i_core_clk);
    pend = dn;
    if (acc) st = neg_flags(d);
  endtask

  // Negates through the bank pointer and both halves of the access bank.
  task automatic neg_banks();
    i_bank_pointer <= 4'h5;
    op(16'h6D3A, 8'h3A, 1'b1, 1'b1, 12'h53A);
    op(16'h6C10, 8'h80, 1'b1, 1'b1, 12'h010);
    op(16'h6C60, 8'h00, 1'b1, 1'b1, 12'hF60);
  endtask

  // Indexed offsets apply only at or below the limit with the access bit clear.
  task automatic neg_indexed();
    i_ext_en <= 1'b1;
    i_fsr2 <= 8'h20;
    op(16'h6C5F, 8'h10, 1'b1, 1'b1, 12'h07F);
    op(16'h6C60, 8'h01, 1'b1, 1'b1, 12'hF60);
    op(16'h6D05, 8'h7F, 1'b1, 1'b1, 12'h505);
    i_ext_en <= 1'b0;
  endtask

  // Both no-operation forms and a near-miss word leave memory and flags alone.
  task automatic nops();
    op(16'h0000, 8'h55, 1'b0, 1'b1, 12'h000);
    op(16'hF123, 8'h55, 1'b0, 1'b1, 12'h000);
    op(16'h6E00, 8'h55, 1'b0, 1'b0, 12'h000);
    op(16'hFFFF, 8'h55, 1'b0, 1'b1, 12'h000);
  endtask

  // Holds reset for five cycles, then runs the scenarios back to back.
  initial begin
    repeat (4) @(posedge i_core_clk);
    @(negedge i_core_clk);
    cmp({o_mem, o_status, o_phase, o_done}, 32'h0);
    @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    neg_banks();
    neg_indexed();
    nops();
    op(16'h0000, 8'h00, 1'b0, 1'b1, 12'h000);
    stop_test();
  end

  // Cuts a hang short well beyond the expected run of about fifty cycles.
  initial begin
    repeat (500) @(posedge i_core_clk);
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
